// *** rtl/brake_pkg.sv ***
// Package with register map, field positions and timing constants
package brake_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          MS_US           = 1000;
    localparam int          CYC_PER_MS      = CLK_HZ / 1000;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CFG        = 8'h00;
    localparam logic [7:0]  ADDR_DOUT       = 8'h04;
    localparam logic [7:0]  ADDR_OVR        = 8'h08;
    localparam logic [7:0]  ADDR_OVAL       = 8'h0c;
    localparam logic [7:0]  ADDR_DLY0       = 8'h10;
    localparam logic [7:0]  ADDR_DLY1       = 8'h14;
    localparam logic [7:0]  ADDR_DLY2       = 8'h18;
    localparam logic [7:0]  ADDR_DLY3       = 8'h1c;
    localparam logic [7:0]  ADDR_FREQ       = 8'h20;
    localparam logic [7:0]  ADDR_DUTY       = 8'h24;
    localparam logic [7:0]  ADDR_STAT       = 8'h28;
    // Field positions
    localparam int          CFG_AUTO_BIT    = 2;
    localparam int          DOUT_BRAKE_BIT  = 0;
    localparam int          OVR_BRAKE_BIT   = 0;
    // Limits and reset values
    localparam logic [15:0] FREQ_MIN        = 16'h0032;
    localparam logic [15:0] FREQ_MAX        = 16'h4e20;
    localparam logic [15:0] FREQ_RST        = 16'h07d0;
    localparam logic [6:0]  DUTY_MIN        = 7'h02;
    localparam logic [6:0]  DUTY_MAX        = 7'h64;
    localparam logic [6:0]  DUTY_RST        = 7'h64;
    localparam logic [15:0] DLY_RST         = 16'h0000;
    localparam logic [31:0] CLK_HZ_W        = 32'h0098_9680;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam logic [1:0]  RESP_DECERR     = 2'b11;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PRE_REL = 3'b001,
        ST_POST_REL= 3'b010,
        ST_RUN     = 3'b011,
        ST_PRE_ENG = 3'b100,
        ST_POST_ENG= 3'b101
    } seq_t;
endpackage

// *** rtl/holding_brake_sequencer_pwm.sv ***
// Holding brake sequencer with PWM output and AXI4-Lite registers
// Functional notes
// - Auto mode: brake engaged unless operation-enabled; act only on entry/exit.
// - Config bit 2 set enables automatic brake sequencing.
// - Config bit 2 clear: brake follows digital-output bit 0.
// - Entry: current on, delay 3, release, delay 4, travel allowed.
// - Exit: standstill, delay 1, engage, delay 2, current off.
// - Released brake output is PWM with configured frequency and duty.
// - Frequency accepted only 50 to 20000 Hz; others refused.
// - Duty accepted only 2 to 100 percent.
// - Duty 100 holds output continuously active.
// - Manual override bit drives brake from manual value word.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module holding_brake_sequencer_pwm
    import brake_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        opEnabled,
    input  wire logic        motorStandstill,
    output logic             motorCurrentOn,
    output logic             stopRequest,
    output logic             travelEnable,
    output logic             brakeOut
);
    import brake_pkg::*;

    logic [31:0] cfg_q;
    logic [31:0] dout_q;
    logic [31:0] ovr_q;
    logic [31:0] oval_q;
    logic [15:0] dly_q [4];
    logic [15:0] freq_q;
    logic [6:0]  duty_q;
    logic        refused_q;
    logic        awHeld_q, wHeld_q;
    logic [31:0] awAddr_q, wData_q;
    logic [3:0]  wStrb_q;
    seq_t        state_q;
    logic [15:0] msCnt_q;
    logic [$clog2(CYC_PER_MS)-1:0] tick_q;
    logic        msTick;
    logic        released;
    logic        autoMode;
    logic [31:0] periodCyc_q;
    logic [31:0] highCyc_q;
    logic [31:0] pwmCnt_q;
    logic        pwmLevel;
    logic        srcLevel;
    logic        opEn_s1_q, opEn_s2_q;

    assign autoMode = cfg_q[CFG_AUTO_BIT];

    // Capture write address and data independently, in either order
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 32'h0;
            wData_q  <= 32'h0;
            wStrb_q  <= 4'h0;
        end
        else if (awHeld_q && wHeld_q)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    // Register writes; out-of-range limits are refused and flagged
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cfg_q       <= 32'h0;
            dout_q      <= 32'h0;
            ovr_q       <= 32'h0;
            oval_q      <= 32'h0;
            for (int i = 0; i < 4; i++)
                dly_q[i] <= DLY_RST;
            freq_q      <= FREQ_RST;
            duty_q      <= DUTY_RST;
            refused_q   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (awHeld_q && wHeld_q)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                // Whole-word writes only; partial strobes leave the register
                if (wStrb_q == 4'hf)
                begin
                    unique case (awAddr_q[7:0])
                        ADDR_CFG:  cfg_q  <= wData_q;
                        ADDR_DOUT: dout_q <= wData_q;
                        ADDR_OVR:  ovr_q  <= wData_q;
                        ADDR_OVAL: oval_q <= wData_q;
                        ADDR_DLY0: dly_q[0] <= wData_q[15:0];
                        ADDR_DLY1: dly_q[1] <= wData_q[15:0];
                        ADDR_DLY2: dly_q[2] <= wData_q[15:0];
                        ADDR_DLY3: dly_q[3] <= wData_q[15:0];
                        ADDR_FREQ:
                        begin
                            if (wData_q[31:16] == 16'h0
                                && wData_q[15:0] >= FREQ_MIN
                                && wData_q[15:0] <= FREQ_MAX)
                                freq_q <= wData_q[15:0];
                            else
                            begin
                                refused_q   <= 1'b1;
                                s_axi_bresp <= RESP_SLVERR;
                            end
                        end
                        ADDR_DUTY:
                        begin
                            if (wData_q[31:7] == 25'h0
                                && wData_q[6:0] >= DUTY_MIN
                                && wData_q[6:0] <= DUTY_MAX)
                                duty_q <= wData_q[6:0];
                            else
                            begin
                                refused_q   <= 1'b1;
                                s_axi_bresp <= RESP_SLVERR;
                            end
                        end
                        ADDR_STAT: refused_q <= 1'b0;      // Write clears
                        default:   s_axi_bresp <= RESP_DECERR;
                    endcase
                end
            end
        end
    end

    // Read channel, one cycle latency
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                ADDR_CFG:  s_axi_rdata <= cfg_q;
                ADDR_DOUT: s_axi_rdata <= dout_q;
                ADDR_OVR:  s_axi_rdata <= ovr_q;
                ADDR_OVAL: s_axi_rdata <= oval_q;
                ADDR_DLY0: s_axi_rdata <= {16'h0, dly_q[0]};
                ADDR_DLY1: s_axi_rdata <= {16'h0, dly_q[1]};
                ADDR_DLY2: s_axi_rdata <= {16'h0, dly_q[2]};
                ADDR_DLY3: s_axi_rdata <= {16'h0, dly_q[3]};
                ADDR_FREQ: s_axi_rdata <= {16'h0, freq_q};
                ADDR_DUTY: s_axi_rdata <= {25'h0, duty_q};
                ADDR_STAT: s_axi_rdata <= {27'h0, released, state_q,
                                           refused_q};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_DECERR;
                end
            endcase
        end
    end

    // Operation-enabled comes from another block; synchronise it
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            opEn_s1_q <= 1'b0;
            opEn_s2_q <= 1'b0;
        end
        else
        begin
            opEn_s1_q <= opEnabled;
            opEn_s2_q <= opEn_s1_q;
        end
    end

    // Free-running millisecond time base
    assign msTick = (tick_q == ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1));
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || msTick)
            tick_q <= '0;
        else
            tick_q <= tick_q + 1'b1;
    end

    // Brake sequence; counter restarts on entry to each timed step
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !autoMode)
        begin
            state_q <= ST_IDLE;
            msCnt_q <= 16'h0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (opEn_s2_q)
                    begin
                        state_q <= ST_PRE_REL;
                        msCnt_q <= 16'h0;
                    end
                ST_PRE_REL:
                    if (msCnt_q >= dly_q[2])
                    begin
                        state_q <= ST_POST_REL;
                        msCnt_q <= 16'h0;
                    end
                    else if (msTick)
                        msCnt_q <= msCnt_q + 16'h1;
                ST_POST_REL:
                    if (msCnt_q >= dly_q[3])
                        state_q <= ST_RUN;
                    else if (msTick)
                        msCnt_q <= msCnt_q + 16'h1;
                ST_RUN:
                    if (!opEn_s2_q && motorStandstill)
                    begin
                        state_q <= ST_PRE_ENG;
                        msCnt_q <= 16'h0;
                    end
                ST_PRE_ENG:
                    if (msCnt_q >= dly_q[0])
                    begin
                        state_q <= ST_POST_ENG;
                        msCnt_q <= 16'h0;
                    end
                    else if (msTick)
                        msCnt_q <= msCnt_q + 16'h1;
                ST_POST_ENG:
                    if (msCnt_q >= dly_q[1])
                        state_q <= ST_IDLE;
                    else if (msTick)
                        msCnt_q <= msCnt_q + 16'h1;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Released only between the two inner steps of the sequence
    assign released = (state_q == ST_POST_REL) || (state_q == ST_RUN)
                   || (state_q == ST_PRE_ENG);

    // PWM period and high time from frequency and duty
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            periodCyc_q <= 32'h1;
            highCyc_q   <= 32'h1;
            pwmCnt_q    <= 32'h0;
        end
        else
        begin
            periodCyc_q <= CLK_HZ_W / {16'h0, freq_q};
            highCyc_q   <= (periodCyc_q * {25'h0, duty_q}) / 32'd100;
            if (pwmCnt_q + 32'h1 >= periodCyc_q)
                pwmCnt_q <= 32'h0;
            else
                pwmCnt_q <= pwmCnt_q + 32'h1;
        end
    end
    assign pwmLevel = (duty_q == DUTY_MAX)
                   || (pwmCnt_q < highCyc_q);

    // Select source: override, auto sequence or manual output bit
    always_comb
    begin
        if (autoMode)
            srcLevel = released && pwmLevel;
        else
            srcLevel = dout_q[DOUT_BRAKE_BIT] && pwmLevel;
        if (ovr_q[OVR_BRAKE_BIT])
            srcLevel = oval_q[OVR_BRAKE_BIT];
    end

    // Registered outputs toward brake and drive state machine
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            brakeOut       <= 1'b0;
            motorCurrentOn <= 1'b0;
            travelEnable   <= 1'b0;
            stopRequest    <= 1'b0;
        end
        else
        begin
            brakeOut       <= srcLevel;
            motorCurrentOn <= !autoMode ? opEn_s2_q
                              : (state_q != ST_IDLE);
            travelEnable   <= !autoMode ? opEn_s2_q
                              : (state_q == ST_RUN && opEn_s2_q);
            stopRequest    <= autoMode && state_q == ST_RUN && !opEn_s2_q;
        end
    end
endmodule

// *** tb/brake_sva.sv ***
// Port-level assertion checker for the holding brake sequencer
`timescale 1ns/100ps
module brake_sva (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        opEnabled,
    input wire logic        motorCurrentOn,
    input wire logic        stopRequest,
    input wire logic        travelEnable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Both halves of a write accepted at one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // Bus answers: fixed latency, held until accepted
    property p_wr_answer;
        s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    // Sequencing: travel only with current, stop only after leaving
    property p_travel_cur;
        travelEnable |-> motorCurrentOn;
    endproperty
    property p_travel_rise;
        $rose(travelEnable) |-> opEnabled && $past(motorCurrentOn);
    endproperty
    property p_stop_rise;
        $rose(stopRequest) |-> !opEnabled && !$past(opEnabled, 2);
    endproperty
    property p_stop_travel;
        $rose(stopRequest) |-> ##[0:2] !travelEnable;
    endproperty

    a_wr_answer: assert property (p_wr_answer)
        else $error("write response not two cycles after accept");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read data not one cycle after accept");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before accept");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped before accept");
    a_r_block: assert property (p_r_block)
        else $error("read address ready while data pending");
    a_b_block: assert property (p_b_block)
        else $error("write ready while response pending");
    a_travel_cur: assert property (p_travel_cur)
        else $error("travel enabled without motor current");
    a_travel_rise: assert property (p_travel_rise)
        else $error("travel enabled out of order");
    a_stop_rise: assert property (p_stop_rise)
        else $error("stop request while drive enabled");
    a_stop_travel: assert property (p_stop_travel)
        else $error("travel still enabled after stop request");
endmodule

bind holding_brake_sequencer_pwm brake_sva u_sva (
    .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .opEnabled, .motorCurrentOn, .stopRequest, .travelEnable
);

// *** tb/brake_model.sv ***
// Far-side model: brake coil timing and motor standstill sense
`timescale 1ns/100ps
module brake_model #(
    parameter int SETTLE = 20
) (
    input  wire logic        clk_sys,
    input  wire logic        brakeOut,
    input  wire logic        stopRequest,
    output logic             motorStandstill,
    output logic [15:0]      highCnt,
    output logic [15:0]      perCnt
);
    logic [15:0] runCnt    = '0;
    logic        prevOut   = 1'b0;
    int          settleCnt = 0;

    initial {motorStandstill, highCnt, perCnt} = '0;

    // Coil on-time and period of the last complete PWM cycle
    always @(posedge clk_sys)
    begin
        runCnt <= runCnt + 16'h1;
        if (brakeOut && !prevOut)
        begin
            perCnt <= runCnt;
            runCnt <= 16'h1;
        end
        if (!brakeOut && prevOut)
            highCnt <= runCnt;
        prevOut <= brakeOut;
    end

    // Motor coasts a while before it reports standstill
    always @(posedge clk_sys)
    begin
        if (!stopRequest)
        begin
            settleCnt       <= 0;
            motorStandstill <= 1'b0;
        end
        else if (settleCnt < SETTLE)
            settleCnt <= settleCnt + 1;
        else
            motorStandstill <= 1'b1;
    end
endmodule

// *** tb/holding_brake_sequencer_pwm_bench.sv ***
// Register-level testbench for the holding brake sequencer
`timescale 1ns/100ps
module holding_brake_sequencer_pwm_bench;
    import brake_pkg::*;
    localparam int LIM  = 2 * CYC_PER_MS + 20;
    localparam int PER  = CLK_HZ / 20000;
    localparam int HIGH = PER * 50 / 100;
    logic clk_sys = 1'b0, sys_rst = 1'b1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, motorCurrentOn, stopRequest, travelEnable;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rdWord;
    logic opEnabled = 1'b0, motorStandstill, brakeOut;
    logic [15:0] highCnt, perCnt;
    int badCount = 0, checks = 0, cycleCount = 0, waitCnt;

    always #50 clk_sys = ~clk_sys;

    holding_brake_sequencer_pwm uut (
        .clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .opEnabled, .motorStandstill,
        .motorCurrentOn, .stopRequest, .travelEnable, .brakeOut
    );
    brake_model u_model (
        .clk_sys, .brakeOut, .stopRequest, .motorStandstill, .highCnt,
        .perCnt
    );

    task automatic finishTest;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("read response", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Write, then read back what the register must now hold
    task automatic try_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [1:0] er, input logic [31:0] kept);
        axi_wr(a, v, er);
        axi_rd(a, rdWord, RESP_OKAY);
        chk("readback", rdWord, kept);
    endtask

    // Brake output must hold one level for a whole window
    task automatic steady(input int len, input logic v, input string nm);
        int hits;
        hits = 0;
        repeat (4) @(posedge clk_sys);
        repeat (len)
        begin
            @(posedge clk_sys);
            if (brakeOut === v) hits++;
        end
        chk(nm, 32'(hits), 32'(len));
    endtask

    // Watchdog at 9.5 ms, well above one sequencing run with three one ms delays
    always @(posedge clk_sys)
    begin
        cycleCount++;
        if (cycleCount == 95000)
        begin
            badCount++;
            finishTest;
        end
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        axi_rd(ADDR_FREQ, rdWord, RESP_OKAY);
        chk("freq reset", rdWord, {16'h0, FREQ_RST});
        axi_rd(ADDR_DUTY, rdWord, RESP_OKAY);
        chk("duty reset", rdWord, {25'h0, DUTY_RST});
        try_wr(ADDR_FREQ, 32'h31, RESP_SLVERR, 32'h7d0);
        try_wr(ADDR_FREQ, 32'h4e21, RESP_SLVERR, 32'h7d0);
        try_wr(ADDR_FREQ, 32'h32, RESP_OKAY, 32'h32);
        try_wr(ADDR_FREQ, 32'h4e20, RESP_OKAY, 32'h4e20);
        try_wr(ADDR_DUTY, 32'h1, RESP_SLVERR, 32'h64);
        try_wr(ADDR_DUTY, 32'h65, RESP_SLVERR, 32'h64);
        try_wr(ADDR_DUTY, 32'h2, RESP_OKAY, 32'h2);
        try_wr(ADDR_DUTY, 32'h64, RESP_OKAY, 32'h64);
        axi_rd(ADDR_STAT, rdWord, RESP_OKAY);
        chk("refused flag", {31'h0, rdWord[0]}, 32'h1);
        axi_rd(8'h40, rdWord, RESP_DECERR);
        chk("unmapped data", rdWord, 32'h0);
        axi_wr(8'h44, 32'h1, RESP_DECERR);
        // Manual control and override, plain on/off at full duty
        axi_wr(ADDR_DOUT, 32'h1, RESP_OKAY);
        steady(600, 1'b1, "manual on");
        axi_wr(ADDR_OVR, 32'h1, RESP_OKAY);
        steady(600, 1'b0, "override low");
        axi_wr(ADDR_OVAL, 32'h1, RESP_OKAY);
        steady(600, 1'b1, "override high");
        axi_wr(ADDR_OVR, 32'h0, RESP_OKAY);
        axi_wr(ADDR_DOUT, 32'h0, RESP_OKAY);
        steady(600, 1'b0, "manual off");
        // Half duty at the top frequency
        axi_wr(ADDR_DUTY, 32'h32, RESP_OKAY);
        axi_wr(ADDR_DOUT, 32'h1, RESP_OKAY);
        repeat (3 * PER) @(posedge clk_sys);
        chk("pwm period", {16'h0, perCnt}, 32'(PER));
        chk("pwm on time", {16'h0, highCnt}, 32'(HIGH));
        axi_wr(ADDR_DOUT, 32'h0, RESP_OKAY);
        // Automatic sequencing: delays 2 to 4 one ms, delay 1 zero
        axi_wr(ADDR_DLY0, 32'h0, RESP_OKAY);
        axi_wr(ADDR_DLY1, 32'h1, RESP_OKAY);
        axi_wr(ADDR_DLY2, 32'h1, RESP_OKAY);
        axi_wr(ADDR_DLY3, 32'h1, RESP_OKAY);
        axi_wr(ADDR_CFG, 32'h4, RESP_OKAY);
        steady(600, 1'b0, "auto idle engaged");
        opEnabled <= 1'b1;
        while (!motorCurrentOn) @(posedge clk_sys);
        chk("brake at current on", {31'h0, brakeOut}, 32'h0);
        waitCnt = 0;
        while (!brakeOut)
        begin
            @(posedge clk_sys);
            waitCnt++;
        end
        chk("release delay", 32'(waitCnt <= LIM), 32'h1);
        chk("travel at release", {31'h0, travelEnable}, 32'h0);
        waitCnt = 0;
        while (!travelEnable)
        begin
            @(posedge clk_sys);
            waitCnt++;
        end
        chk("travel delay", 32'(waitCnt <= LIM), 32'h1);
        repeat (3 * PER) @(posedge clk_sys);
        chk("auto pwm period", {16'h0, perCnt}, 32'(PER));
        chk("auto pwm on time", {16'h0, highCnt}, 32'(HIGH));
        // Status shows released brake in run state, refusal still latched
        axi_rd(ADDR_STAT, rdWord, RESP_OKAY);
        chk("run status", rdWord, {27'h0, 1'b1, ST_RUN, 1'b1});
        axi_wr(ADDR_STAT, 32'h0, RESP_OKAY);
        axi_rd(ADDR_STAT, rdWord, RESP_OKAY);
        chk("refused cleared", {31'h0, rdWord[0]}, 32'h0);
        axi_wr(ADDR_DUTY, 32'h64, RESP_OKAY);
        opEnabled <= 1'b0;
        // Standstill is only momentary in the model, so look as it arrives
        while (!motorStandstill) @(posedge clk_sys);
        chk("brake held to standstill", {31'h0, brakeOut}, 32'h1);
        chk("stop before engage", {31'h0, stopRequest}, 32'h1);
        while (brakeOut) @(posedge clk_sys);
        chk("current at engage", {31'h0, motorCurrentOn}, 32'h1);
        waitCnt = 0;
        while (motorCurrentOn)
        begin
            @(posedge clk_sys);
            waitCnt++;
        end
        chk("current off delay", 32'(waitCnt <= LIM), 32'h1);
        steady(600, 1'b0, "engaged after exit");
        finishTest;
    end
endmodule
